// ### rtl/pbp_pkg.sv
// Shared constants and carrier types of the port bypass channel
package pbp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOSS_LAT_NS = 400;
  // Longest time, so round down, never below one cycle
  localparam int LOSS_LAT_CYC = (LOSS_LAT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                LOSS_LAT_NS / CLK_PERIOD_NS;
  // Pin to filtered value latency of the input filter, in cycles
  localparam int FILT_LAT_CYC = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'h2A;
  localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] ISTAT_ADDR = 8'hB0;
  localparam logic [7:0] ICLR_ADDR = 8'hB4;
  localparam logic [7:0] IEN_ADDR = 8'hB8;
  localparam logic [7:0] ISRC_ADDR = 8'hBC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EN_BIT = 7;
  localparam int IRQEN_BIT = 6;
  localparam int FB_BIT = 1;
  localparam int SD_BIT = 0;
  localparam int EV_EDGE = 0;
  localparam int EV_LOSS = 1;
  localparam int EV_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic EN_RST = 1'b0;
  localparam logic IRQEN_RST = 1'b0;
  localparam logic FB_RST = 1'b1;
  localparam logic PIN_RST = 1'b1;
  localparam logic [1:0] IMASK_RST = 2'h3;
  localparam logic [7:0] ISRC_RST = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe_n;
  } pbp_pin_t;

  typedef struct packed {
    logic en;
    logic irq_en;
    logic force_n;
  } pbp_ctrl_t;

endpackage

// ### rtl/pbp_in_filter.sv
// Two-flop synchroniser and agreement filter for pin inputs
`timescale 1ns/1ps
module pbp_in_filter #(
  parameter int W = 2
) (
  pclk,    // core clock
  presetn, // async reset, active low
  pin_i,   // raw pin levels
  filt     // synchronised and filtered levels
);
  import pbp_pkg::*;
  input wire logic pclk;
  input wire logic presetn;
  input wire logic [W-1:0] pin_i;
  output logic [W-1:0] filt;

  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] age_q;
  logic [W-1:0] hold_q;
  wire [W-1:0] agree;

  if (W < 1) begin : g_chk
    $error("pbp_in_filter needs W of at least 1");
  end

  // ----------------------------------------------------------------
  // Synchroniser; pins idle high through their pull-ups
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= {W{PIN_RST}};
      sync2_q <= {W{PIN_RST}};
      age_q <= {W{PIN_RST}};
      hold_q <= {W{PIN_RST}};
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      age_q <= sync2_q;
      hold_q <= filt;
    end
  end

  // ----------------------------------------------------------------
  // A new level is taken once two samples agree
  // ----------------------------------------------------------------
  assign agree = ~(sync2_q ^ age_q);
  assign filt = (agree & sync2_q) | (~agree & hold_q);

endmodule

// ### rtl/pbp_channel.sv
// Port bypass channel: control register, pin pair and interrupt logic
//
// Behaviour
// - Detect interrupt enable set: any level change on detect pin raises interrupt.
// - Qualifying change asserts irq_n low and loads source index with own address.
// - Detect interrupt enable clear: detect pin changes raise no interrupt; a loss while enabled with force bit one still does.
// - Channel enabled: port5 bit5 driven totem-pole, level follows force bit.
// - Force bit one leaves external force-bypass deasserted, normal mode.
// - Force bit zero asserts external force-bypass, bypass mode.
// - Channel enabled: filtered detect low clears force bit; pin falls within 400 ns.
// - Register reads return synchronised, filtered pin levels.
// - Force bit writes honoured any time while detect input stays high.
// - Channel enabled: detect bit is read-only, shows port5 bit4 level.
// - Detect bit one means signal seen, zero means no signal.
// - Channel enable makes the pin pair force output and detect input.
// - Channel enable clear: other control bits leave both pins alone.
`timescale 1ns/1ps
module pbp_channel (
  pclk,             // core clock, 10 MHz
  presetn,          // async reset, active low
  psel,             // APB select
  penable,          // APB access phase
  pwrite,           // APB write
  paddr,            // APB byte address
  pwdata,           // APB write data
  prdata,           // APB read data
  pready,           // APB ready
  pslverr,          // APB error on unmapped address
  port5_bit5_pin_i, // force bypass pin level
  port5_bit5_pin,   // force bypass pin drive
  port5_bit4_pin_i, // signal detect pin level
  port5_bit4_pin,   // signal detect pin drive
  irq_n             // interrupt, active low
);
  import pbp_pkg::*;
  input wire logic pclk;
  input wire logic presetn;
  input wire logic psel;
  input wire logic penable;
  input wire logic pwrite;
  input wire logic [7:0] paddr;
  input wire logic [31:0] pwdata;
  output logic [31:0] prdata;
  output logic pready;
  output logic pslverr;
  input wire logic port5_bit5_pin_i;
  output pbp_pkg::pbp_pin_t port5_bit5_pin;
  input wire logic port5_bit4_pin_i;
  output pbp_pkg::pbp_pin_t port5_bit4_pin;
  output logic irq_n;

  if (FILT_LAT_CYC + 1 > LOSS_LAT_CYC) begin : g_chk
    $error("Filter too slow for the signal loss latency");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pbp_ctrl_t ctrl_q, ctrl_d;
  logic [EV_W-1:0] istat_q, istat_d;
  logic [EV_W-1:0] ien_q, ien_d;
  logic [7:0] isrc_q, isrc_d;
  logic [31:0] prdata_q, prdata_d;
  logic irq_n_q, irq_n_d;
  logic sd_prev_q;
  logic [1:0] filt;

  // ----------------------------------------------------------------
  // Pin input synchroniser and filter
  // ----------------------------------------------------------------
  pbp_in_filter #(.W(2)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .pin_i({port5_bit5_pin_i, port5_bit4_pin_i}),
    .filt(filt)
  );

  wire fb_pin = filt[1];
  wire sd_pin = filt[0];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = paddr == CTRL_ADDR;
  wire hit_istat = paddr == ISTAT_ADDR;
  wire hit_iclr = paddr == ICLR_ADDR;
  wire hit_ien = paddr == IEN_ADDR;
  wire hit_isrc = paddr == ISRC_ADDR;
  wire mapped = hit_ctrl | hit_istat | hit_iclr | hit_ien | hit_isrc;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_iclr = wr & hit_iclr;
  wire wr_ien = wr & hit_ien;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Control byte as software sees it; pin bits come from the filter
  function automatic logic [7:0] ctrl_view(pbp_ctrl_t c, logic fb,
                                           logic sd);
    logic [7:0] v;
    v = 8'h00;
    v[EN_BIT] = c.en;
    v[IRQEN_BIT] = c.irq_en;
    v[FB_BIT] = fb;
    v[SD_BIT] = sd;
    return v;
  endfunction

  // Read data is captured in the setup cycle, valid in the access phase
  assign prdata_d = !setup ? prdata_q :
                    hit_ctrl ? {24'h000000,
                                ctrl_view(ctrl_q, fb_pin, sd_pin)} :
                    hit_istat ? {30'h0, istat_q} :
                    hit_ien ? {30'h0, ien_q} :
                    hit_isrc ? {24'h000000, isrc_q} :
                    32'h00000000;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  wire sd_edge = sd_pin ^ sd_prev_q;
  wire loss = ctrl_q.en & ~sd_pin;
  wire fb_written = wr_ctrl ? pwdata[FB_BIT] : ctrl_q.force_n;
  wire fb_lost = loss & ctrl_q.force_n;

  assign ctrl_d.en = wr_ctrl ? pwdata[EN_BIT] : ctrl_q.en;
  assign ctrl_d.irq_en = wr_ctrl ? pwdata[IRQEN_BIT] : ctrl_q.irq_en;
  // Hardware clear wins over a write while the signal is lost
  assign ctrl_d.force_n = loss ? 1'b0 : fb_written;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire ev_edge = ctrl_q.irq_en & sd_edge;
  wire [EV_W-1:0] ev_set = {fb_lost, ev_edge};
  wire [EV_W-1:0] ev_clr = wr_iclr ? pwdata[EV_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  assign istat_d = (istat_q & ~ev_clr) | ev_set;
  assign ien_d = wr_ien ? pwdata[EV_W-1:0] : ien_q;
  assign isrc_d = ev_edge ? CTRL_IDX : isrc_q;
  assign irq_n_d = ~|(istat_d & ien_d);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Released when disabled; pull-ups and other pin users take over
  assign port5_bit5_pin.o = ctrl_q.en & ctrl_q.force_n;
  assign port5_bit5_pin.oe_n = ~ctrl_q.en;
  assign port5_bit4_pin.o = 1'b0;
  assign port5_bit4_pin.oe_n = 1'b1;
  assign prdata = prdata_q;
  assign irq_n = irq_n_q;

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '{en: EN_RST, irq_en: IRQEN_RST, force_n: FB_RST};
      istat_q <= '0;
      ien_q <= IMASK_RST;
      isrc_q <= ISRC_RST;
      prdata_q <= 32'h00000000;
      irq_n_q <= 1'b1;
      sd_prev_q <= PIN_RST;
    end else begin
      ctrl_q <= ctrl_d;
      istat_q <= istat_d;
      ien_q <= ien_d;
      isrc_q <= isrc_d;
      prdata_q <= prdata_d;
      irq_n_q <= irq_n_d;
      sd_prev_q <= sd_pin;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_irq_armed;
    ctrl_q.irq_en && ien_q[EV_EDGE];
  endsequence

  sequence s_detect_edge;
    sd_pin != sd_prev_q;
  endsequence

  sequence s_pin_lost;
    ctrl_q.en && !port5_bit4_pin_i && !wr_ctrl;
  endsequence

  edge_irq_a: assert property (
    s_irq_armed ##0 s_detect_edge |=> !irq_n && istat_q[EV_EDGE])
    else $error("Detect edge did not raise the interrupt");

  edge_src_a: assert property (
    ctrl_q.irq_en && (sd_pin != sd_prev_q) |=> isrc_q == CTRL_IDX)
    else $error("Source index not loaded with own address");

  edge_quiet_a: assert property (
    !ctrl_q.irq_en && !wr_iclr && !istat_q[EV_EDGE]
    |=> !istat_q[EV_EDGE])
    else $error("Edge flagged with detect interrupt disabled");

  drive_follow_a: assert property (
    ctrl_q.en |-> !port5_bit5_pin.oe_n
                  && port5_bit5_pin.o == ctrl_q.force_n)
    else $error("Force pin not driven from the force bit");

  bypass_level_a: assert property (
    ctrl_q.en && !ctrl_q.force_n |-> port5_bit5_pin.o == 1'b0)
    else $error("Bypass not asserted while force bit is zero");

  loss_latency_a: assert property (
    ctrl_q.en && !wr_ctrl && !port5_bit4_pin_i [*4]
    |=> !port5_bit5_pin.o)
    else $error("Force pin still high 400 ns after signal loss");

  loss_hold_a: assert property (
    s_pin_lost [*3] ##1 s_pin_lost |=> !ctrl_q.force_n [*2])
    else $error("Force bit not held clear during signal loss");

  read_filtered_a: assert property (
    psel && !penable && hit_ctrl
    |=> prdata[SD_BIT] == $past(filt[0])
        && prdata[FB_BIT] == $past(filt[1]))
    else $error("Control read does not show filtered pin levels");

  write_fb_a: assert property (
    wr_ctrl && sd_pin && ctrl_q.en
    |=> ctrl_q.force_n == $past(pwdata[FB_BIT]))
    else $error("Force bit write not honoured with signal present");

  idle_pins_a: assert property (
    !ctrl_q.en |-> port5_bit5_pin.oe_n && port5_bit4_pin.oe_n
                   && !port5_bit5_pin.o)
    else $error("Pins disturbed while channel is disabled");

  detect_input_a: assert property (
    port5_bit4_pin.oe_n)
    else $error("Detect pin driven by the channel");

  edge_once_a: assert property (
    s_detect_edge |=> sd_pin == sd_prev_q)
    else $error("Detect edge recorded twice");

  set_wins_a: assert property (
    ev_edge && wr_iclr && pwdata[EV_EDGE] |=> istat_q[EV_EDGE])
    else $error("Clear overrode a simultaneous edge event");

  sequence s_signal_low;
    ctrl_q.en && !sd_pin;
  endsequence

  loss_clear_a: assert property (
    s_signal_low |=> !ctrl_q.force_n)
    else $error("Force bit not cleared by filtered signal loss");

  loss_event_a: assert property (
    s_signal_low ##0 ctrl_q.force_n |=> istat_q[EV_LOSS])
    else $error("Loss of signal not recorded in status");

  loss_sticky_a: assert property (
    istat_q[EV_LOSS] && !(wr_iclr && pwdata[EV_LOSS])
    |=> istat_q[EV_LOSS])
    else $error("Loss event dropped without a clear");

  normal_level_a: assert property (
    ctrl_q.en && ctrl_q.force_n |-> port5_bit5_pin.o == 1'b1)
    else $error("Force pin low while force bit is one");

  src_hold_a: assert property (
    !ev_edge |=> $stable(isrc_q))
    else $error("Source index changed without a qualifying edge");

  src_quiet_a: assert property (
    !ctrl_q.irq_en |=> $stable(isrc_q))
    else $error("Source index loaded with detect interrupt off");

  irq_level_a: assert property (
    irq_n == ~|(istat_q & ien_q))
    else $error("Interrupt level disagrees with enabled status");

  irq_hold_a: assert property (
    !irq_n && !wr_iclr && !wr_ien |=> !irq_n)
    else $error("Interrupt released without a clear");

  reserved_zero_a: assert property (
    psel && !penable && hit_ctrl
    |=> prdata[31:8] == 24'h000000 && prdata[5:2] == 4'h0)
    else $error("Reserved control bits read as nonzero");

  disabled_hold_a: assert property (
    !ctrl_q.en && !wr_ctrl
    |=> ctrl_q.force_n == $past(ctrl_q.force_n))
    else $error("Force bit changed by hardware while disabled");

endmodule

// ### verif/pbp_ext_model.sv
// Model of the external loop bypass, clock recovery and detect circuit
`timescale 1ns/1ps
module pbp_ext_model (
  input wire pbp_pkg::pbp_pin_t fb_pin, // force bypass drive from channel
  input wire pbp_pkg::pbp_pin_t sd_pin, // detect pin drive from channel
  input wire logic sig_on,              // high-speed signal on the loop
  output logic fb_level,                // resolved force bypass wire
  output logic sd_level,                // resolved detect wire
  output logic bypass                   // loop circuit in bypass mode
);
  import pbp_pkg::*;
  // --------------------------------------------------------------
  // Wire resolution
  // --------------------------------------------------------------
  // Weak pull-up holds the force wire high when released
  assign fb_level = fb_pin.oe_n ? 1'b1 : fb_pin.o;
  // Detect output of the unit, driven at all times
  assign sd_level = sd_pin.oe_n ? sig_on : sd_pin.o;
  // Low force input selects bypass mode
  assign bypass = ~fb_level;
endmodule

// ### verif/port_bypass_control_pair_tb.sv
// Self-checking bench of the port bypass channel
`timescale 1ns/1ps
module port_bypass_control_pair_tb;
  import pbp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_n, fb_level, sd_level, bypass;
  logic sig_on = 1'b1;
  pbp_pin_t fb_pin, sd_pin;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  always #50 pclk = ~pclk;

  pbp_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port5_bit5_pin_i(fb_level), .port5_bit5_pin(fb_pin),
    .port5_bit4_pin_i(sd_level), .port5_bit4_pin(sd_pin), .irq_n(irq_n));
  pbp_ext_model ext_u (.fb_pin(fb_pin), .sd_pin(sd_pin), .sig_on(sig_on),
    .fb_level(fb_level), .sd_level(sd_level), .bypass(bypass));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task stop_test;
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_n(input int c);
    repeat (c) @(negedge pclk);
  endtask

  // Change the detect line, count rising edges until the output falls
  // First negedge comes before the first edge, hence the start at -1
  task sig_to(input logic v, input bit on_irq);
    @(posedge pclk);
    sig_on <= v;
    n = -1;
    do begin
      @(negedge pclk);
      n++;
    end while ((on_irq ? irq_n : fb_pin.o) !== 1'b0 && n < 20);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_reset;
    chk(irq_n, 1'b1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'({EN_RST, IRQEN_RST, 4'h0, PIN_RST, 1'b1}));
    apb(1'b0, IEN_ADDR, 32'h0);
    chk(rd, 32'(IMASK_RST));
    apb(1'b0, ISRC_ADDR, 32'h0);
    chk(rd, 32'(ISRC_RST));
    apb(1'b1, 8'h10, 32'hFF);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h0);
    wait_n(5);
    chk({fb_pin.oe_n, fb_level, bypass}, 3'b110);
  endtask

  task t_enable;
    logic dflt;
    apb(1'b0, CTRL_ADDR, 32'h0);
    dflt = rd[FB_BIT];
    apb(1'b1, CTRL_ADDR, 32'({dflt, 1'b0}));
    apb(1'b1, CTRL_ADDR, 32'({2'b10, 4'h0, dflt, 1'b0}));
    wait_n(5);
    chk({fb_pin.oe_n, fb_pin.o, sd_pin.oe_n}, 3'b011);
    chk(bypass, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h80);
    wait_n(5);
    chk({fb_pin.o, bypass}, 2'b01);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h81);
    apb(1'b1, CTRL_ADDR, 32'h82);
    wait_n(5);
    chk(fb_pin.o, 1'b1);
  endtask

  task t_loss;
    sig_to(1'b0, 1'b0);
    chk(32'(n <= LOSS_LAT_CYC), 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h83);
    wait_n(5);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h80);
    chk({fb_pin.o, irq_n}, 2'b00);
    apb(1'b0, ISTAT_ADDR, 32'h0);
    chk(rd[EV_LOSS], 1'b1);
    sig_to(1'b1, 1'b0);
    wait_n(5);
    apb(1'b1, CTRL_ADDR, 32'h82);
    apb(1'b1, ICLR_ADDR, 32'h3);
    wait_n(5);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk({rd[30:0], irq_n}, {31'h83, 1'b1});
  endtask

  task t_irq;
    apb(1'b1, CTRL_ADDR, 32'h42);
    apb(1'b1, ICLR_ADDR, 32'h3);
    for (int i = 0; i < 2; i++) begin
      sig_to(i[0], 1'b1);
      chk(n, FILT_LAT_CYC + 1);
      apb(1'b0, ISRC_ADDR, 32'h0);
      chk(rd, 32'(CTRL_IDX));
      apb(1'b0, ISTAT_ADDR, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, ICLR_ADDR, 32'h1);
      wait_n(3);
      chk(irq_n, 1'b1);
    end
    // Clear lands on the same edge as a new detect event
    @(posedge pclk);
    sig_on <= 1'b0;
    @(posedge pclk);
    apb(1'b1, ICLR_ADDR, 32'h1);
    apb(1'b0, ISTAT_ADDR, 32'h0);
    chk({rd[30:0], irq_n}, 32'h2);
    apb(1'b1, ICLR_ADDR, 32'h1);
    sig_to(1'b1, 1'b1);
    chk(n, FILT_LAT_CYC + 1);
    apb(1'b1, ICLR_ADDR, 32'h1);
    apb(1'b1, IEN_ADDR, 32'h0);
    sig_to(1'b0, 1'b1);
    chk(irq_n, 1'b1);
    apb(1'b1, IEN_ADDR, 32'h3);
    wait_n(1);
    chk(irq_n, 1'b0);
    sig_to(1'b1, 1'b1);
    wait_n(5);
    apb(1'b1, ICLR_ADDR, 32'h3);
    apb(1'b1, CTRL_ADDR, 32'h02);
    for (int i = 0; i < 2; i++) begin
      sig_to(i[0], 1'b1);
      apb(1'b0, ISTAT_ADDR, 32'h0);
      chk({rd[30:0], irq_n}, 32'h1);
    end
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_enable;
    t_loss;
    t_irq;
    stop_test;
  end
endmodule
